// File: hw/csd_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          chip standby controller.
// Assumes: Word-spaced register offsets on the plain register port.
// Notes:   Included by the controller and the bench.
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSD_A_STPT  8'h00
`define CSD_A_PSC   8'h04
`define CSD_A_OSCM  8'h08
`define CSD_A_VMON  8'h0C
`define CSD_A_PMSK  8'h10
`define CSD_A_WMSK0 8'h14
`define CSD_A_WMSK1 8'h18
`define CSD_A_WFLG0 8'h1C
`define CSD_A_WFLG1 8'h20
`define CSD_A_WCLR0 8'h24
`define CSD_A_WCLR1 8'h28
`define CSD_A_HOLD  8'h2C
`define CSD_A_RSTF  8'h30
`define CSD_A_STAT  8'h34
`define CSD_A_PLL   8'h38
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSD_B_STPTRG 0
`define CSD_B_DSTRG  1
`define CSD_B_MOSC   0
`define CSD_B_HSOSC  1
`define CSD_B_PLLM   2
`define CSD_B_DETEN  0
`define CSD_B_DSRST  0
`define CSD_B_PLLEN  0
// ----------------------------------------------------------------
// Reset values, vectors and counts
// ----------------------------------------------------------------
`define CSD_R_OSCM   3'h0
`define CSD_R_PLLEN  1'b1
`define CSD_CYC_BASE 32'hFE80_0000
`define CSD_OFS_FNMI 32'h0000_00E0
`define CSD_OFS_FINT 32'h0000_00F0
`define CSD_WAKE_RST 4'h2
`endif

// File: hw/csd_pkg.sv
// Purpose: Types of the chip standby controller.
// Assumes: Nothing.
// Notes:   One-hot mode codes.
package csd_pkg;
  typedef enum logic [4:0] {
    CSD_RUN   = 5'h01,
    CSD_ENTER = 5'h02,
    CSD_STOP  = 5'h04,
    CSD_DEEP  = 5'h08,
    CSD_WAKE  = 5'h10
  } csd_state_t;
endpackage

// File: hw/csd_ctrl.sv
// Purpose: Chip standby controller for STOP and DeepSTOP.
// Assumes: Always-on clock; firmware prepares masks before triggers.
// Functional notes
// - Stop trigger write gates CPU clocks
// - Trigger self-clears; CPU clock cut while set
// - Wake clears trigger, records factor-0 flags
// - Unmasked oscillators stop; slow oscillator runs
// - STOP keeps RAM and I/O state
// - Unmasked factor-0 wake returns STOP to RUN
// - Sticky wake flags, cleared via clear registers
// - Deep-stop trigger write starts DeepSTOP
// - DeepSTOP powers off isolated area, oscillators (oscm_ff-masked main and fast oscillators keep running)
// - PLL off at DeepSTOP until firmware restart
// - HV oscillator follows detect-enable in DeepSTOP
// - Masked always-on peripheral clocks keep running
// - I/O frozen at DeepSTOP until released
// - Factor-0 DeepSTOP wake: reset vector or fatal
// - Factor-1 wake: cyclic run, retention base
// - Local RAM undefined after DeepSTOP
// - Reset flag records DeepSTOP return
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "csd_cfg.svh"
module csd_ctrl
  import csd_pkg::*;
#(
  parameter int          NWK       = 8,
  parameter int          NPER      = 8,
  parameter int          NHOLD     = 8,
  parameter logic [31:0] RESET_VEC = 32'h0000_0000
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wr_data_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rd_data_o,
  input  wire logic [NWK-1:0]   wake0_i,
  input  wire logic [NWK-1:0]   wake1_i,
  input  wire logic             fatal_nmi_i,
  input  wire logic             fatal_interrupt_i,
  output logic                  cpu_clk_en_o,
  output logic                  main_osc_en_o,
  output logic                  fast_osc_en_o,
  output logic                  pll_en_o,
  output logic                  hv_osc_en_o,
  output logic                  iso_pwr_en_o,
  output logic                  local_ram_pwr_o,
  output logic      [NPER-1:0]  periph_clk_en_o,
  output logic      [NHOLD-1:0] io_hold_o,
  output logic                  cpu_reset_o,
  output logic                  cyclic_mode_o,
  output logic      [31:0]      boot_vector_o
);

  if (NWK < 1 || NWK > 32 || NPER < 1 || NPER > 32 ||
      NHOLD < 1 || NHOLD > 32) begin : g_chk
    $error("csd_ctrl: widths must lie in 1..32");
  end

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  csd_state_t       state_ff;
  csd_state_t       nxt_state;
  logic             trig_ff;
  logic             psc_ff;
  logic [2:0]       oscm_ff;
  logic             vmon_ff;
  logic [NPER-1:0]  pmsk_ff;
  logic [NWK-1:0]   wmsk0_ff;
  logic [NWK-1:0]   wmsk1_ff;
  logic [NWK-1:0]   flag0_ff;
  logic [NWK-1:0]   flag1_ff;
  logic [NHOLD-1:0] hold_ff;
  logic             rstf_ff;
  logic             pll_ff;
  logic             cyc_ff;
  logic [31:0]      vec_ff;
  logic [3:0]       cnt_ff;
  logic [31:0]      rdata_ff;
  logic [31:0]      nxt_rdata;
  logic [NWK-1:0]   ev0;
  logic [NWK-1:0]   ev1;
  logic             w0;
  logic             w1;
  logic             standby;
  logic             deep;
  logic             deep_in;

  wire logic wr_stpt = wr_i && addr_i == `CSD_A_STPT;
  wire logic wr_psc  = wr_i && addr_i == `CSD_A_PSC;
  wire logic wr_clr0 = wr_i && addr_i == `CSD_A_WCLR0;
  wire logic wr_clr1 = wr_i && addr_i == `CSD_A_WCLR1;
  wire logic wr_hold = wr_i && addr_i == `CSD_A_HOLD;
  wire logic wr_rstf = wr_i && addr_i == `CSD_A_RSTF;
  wire logic wr_pll  = wr_i && addr_i == `CSD_A_PLL;
  wire logic [31:0] wake_base = w0 ? RESET_VEC : `CSD_CYC_BASE;

  assign ev0     = wake0_i & ~wmsk0_ff;
  assign ev1     = wake1_i & ~wmsk1_ff;
  assign w0      = |ev0;
  assign w1      = |ev1;
  assign deep    = state_ff == CSD_DEEP;
  assign standby = state_ff == CSD_STOP || deep;
  assign deep_in = state_ff == CSD_RUN && nxt_state == CSD_DEEP;

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CSD_RUN: begin
        if (psc_ff) nxt_state = CSD_DEEP;
        else if (trig_ff) nxt_state = CSD_ENTER;
      end
      CSD_ENTER: nxt_state = w0 ? CSD_RUN : CSD_STOP;
      CSD_STOP:  if (w0) nxt_state = CSD_RUN;
      CSD_DEEP:  if (w0 || w1) nxt_state = CSD_WAKE;
      CSD_WAKE:  if (cnt_ff == 4'h0) nxt_state = CSD_RUN;
      default:   nxt_state = CSD_RUN;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) state_ff <= CSD_RUN;
    else state_ff <= nxt_state;
  end
  // Holds the CPU in reset for a few cycles after a DeepSTOP wake
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) cnt_ff <= 4'h0;
    else if (deep && (w0 || w1)) cnt_ff <= `CSD_WAKE_RST - 4'h1;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  end
  // Trigger bits clear themselves once the mode is taken
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) trig_ff <= 1'b0;
    else if (state_ff == CSD_ENTER || state_ff == CSD_STOP)
      trig_ff <= 1'b0;
    else if (wr_stpt && state_ff == CSD_RUN)
      trig_ff <= wr_data_i[`CSD_B_STPTRG];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) psc_ff <= 1'b0;
    else if (deep_in) psc_ff <= 1'b0;
    else if (wr_psc && state_ff == CSD_RUN)
      psc_ff <= wr_data_i[`CSD_B_DSTRG];
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      oscm_ff  <= `CSD_R_OSCM;
      vmon_ff  <= 1'b0;
      pmsk_ff  <= '0;
      wmsk0_ff <= '1;
      wmsk1_ff <= '1;
    end else if (wr_i) begin
      case (addr_i)
        `CSD_A_OSCM:  oscm_ff  <= wr_data_i[2:0];
        `CSD_A_VMON:  vmon_ff  <= wr_data_i[`CSD_B_DETEN];
        `CSD_A_PMSK:  pmsk_ff  <= wr_data_i[NPER-1:0];
        `CSD_A_WMSK0: wmsk0_ff <= wr_data_i[NWK-1:0];
        `CSD_A_WMSK1: wmsk1_ff <= wr_data_i[NWK-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake flags: an event in the clear cycle still sets the flag
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NWK; i++) begin : g_flag
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        flag0_ff[i] <= 1'b0;
        flag1_ff[i] <= 1'b0;
      end else begin
        if (ev0[i]) flag0_ff[i] <= 1'b1;
        else if (wr_clr0 && wr_data_i[i]) flag0_ff[i] <= 1'b0;
        if (ev1[i]) flag1_ff[i] <= 1'b1;
        else if (wr_clr1 && wr_data_i[i]) flag1_ff[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // I/O hold, PLL enable, reset flag, wake vector
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) hold_ff <= '0;
    else if (deep_in) hold_ff <= '1;
    else if (wr_hold) hold_ff <= hold_ff & wr_data_i[NHOLD-1:0];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) pll_ff <= `CSD_R_PLLEN;
    else if (deep_in) pll_ff <= 1'b0;
    else if (wr_pll) pll_ff <= wr_data_i[`CSD_B_PLLEN];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) rstf_ff <= 1'b0;
    else if (deep && (w0 || w1)) rstf_ff <= 1'b1;
    else if (wr_rstf && wr_data_i[`CSD_B_DSRST]) rstf_ff <= 1'b0;
  end
  // Factor 0 has priority over factor 1; NMI over interrupt
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cyc_ff <= 1'b0;
      vec_ff <= RESET_VEC;
    end else if (deep && (w0 || w1)) begin
      cyc_ff <= !w0;
      if (fatal_nmi_i) vec_ff <= wake_base + `CSD_OFS_FNMI;
      else if (fatal_interrupt_i) vec_ff <= wake_base + `CSD_OFS_FINT;
      else vec_ff <= wake_base;
    end
  end

  // ----------------------------------------------------------------
  // Clock, power and hold outputs
  // ----------------------------------------------------------------
  assign cpu_clk_en_o    = state_ff == CSD_RUN && !trig_ff;
  assign main_osc_en_o   = !standby || oscm_ff[`CSD_B_MOSC];
  assign fast_osc_en_o   = !standby || oscm_ff[`CSD_B_HSOSC];
  assign pll_en_o        = pll_ff && !deep && state_ff != CSD_WAKE &&
                           (state_ff != CSD_STOP ||
                            (oscm_ff[`CSD_B_MOSC] &&
                             oscm_ff[`CSD_B_PLLM]));
  assign hv_osc_en_o     = !deep || vmon_ff;
  assign iso_pwr_en_o    = !deep;
  // Local RAM sits in the isolated area; retention RAM does not
  assign local_ram_pwr_o = !deep;
  assign periph_clk_en_o = standby ? pmsk_ff : '1;
  assign io_hold_o       = hold_ff |
                           {NHOLD{state_ff == CSD_STOP}};
  assign cpu_reset_o     = state_ff == CSD_WAKE;
  assign cyclic_mode_o   = cyc_ff;
  assign boot_vector_o   = vec_ff;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_i)
      `CSD_A_STPT:  nxt_rdata[`CSD_B_STPTRG] = trig_ff;
      `CSD_A_PSC:   nxt_rdata[`CSD_B_DSTRG]  = psc_ff;
      `CSD_A_OSCM:  nxt_rdata[2:0]           = oscm_ff;
      `CSD_A_VMON:  nxt_rdata[`CSD_B_DETEN]  = vmon_ff;
      `CSD_A_PMSK:  nxt_rdata[NPER-1:0]      = pmsk_ff;
      `CSD_A_WMSK0: nxt_rdata[NWK-1:0]       = wmsk0_ff;
      `CSD_A_WMSK1: nxt_rdata[NWK-1:0]       = wmsk1_ff;
      `CSD_A_WFLG0: nxt_rdata[NWK-1:0]       = flag0_ff;
      `CSD_A_WFLG1: nxt_rdata[NWK-1:0]       = flag1_ff;
      `CSD_A_HOLD:  nxt_rdata[NHOLD-1:0]     = hold_ff;
      `CSD_A_RSTF:  nxt_rdata[`CSD_B_DSRST]  = rstf_ff;
      `CSD_A_STAT:  nxt_rdata[5:0]           = {cyc_ff, state_ff};
      `CSD_A_PLL:   nxt_rdata[`CSD_B_PLLEN]  = pll_ff;
      default:      nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= rd_i ? nxt_rdata : 32'h0000_0000;
  end
  assign rd_data_o = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_stop_req;
    state_ff == CSD_RUN && trig_ff && !psc_ff;
  endsequence
  sequence s_enter_quiet;
    state_ff == CSD_ENTER && !w0;
  endsequence
  sequence s_deep_wake0;
    deep && w0;
  endsequence

  property p_stop_seq;
    s_stop_req |=> s_enter_quiet |=> state_ff == CSD_STOP && !trig_ff;
  endproperty
  a_stop_seq: assert property (p_stop_seq)
    else $error("stop entry sequence broken");

  property p_cpu_gate;
    s_stop_req |-> !cpu_clk_en_o ##1 !cpu_clk_en_o;
  endproperty
  a_cpu_gate: assert property (p_cpu_gate)
    else $error("CPU clock not gated on stop");

  property p_stop_wake;
    state_ff == CSD_STOP && w0 |=>
      state_ff == CSD_RUN && !trig_ff && cpu_clk_en_o;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("STOP wake did not return to RUN");

  property p_flag_set;
    w0 |=> (flag0_ff & $past(ev0)) == $past(ev0);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("wake flag not recorded");

  property p_osc_stop;
    state_ff == CSD_STOP |->
      main_osc_en_o == oscm_ff[`CSD_B_MOSC] &&
      fast_osc_en_o == oscm_ff[`CSD_B_HSOSC];
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator enable wrong in STOP");

  property p_deep_entry;
    state_ff == CSD_RUN && psc_ff |=>
      deep && !iso_pwr_en_o && !pll_en_o && (&hold_ff);
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("DeepSTOP entry incomplete");

  property p_pll_off;
    !pll_ff && !wr_pll |=> !pll_ff;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("PLL restarted without firmware");

  property p_deep_outs;
    deep |-> hv_osc_en_o == vmon_ff && periph_clk_en_o == pmsk_ff;
  endproperty
  a_deep_outs: assert property (p_deep_outs)
    else $error("DeepSTOP clock enable wrong");

  property p_hold_keep;
    hold_ff[0] && !wr_hold |=> hold_ff[0];
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("I/O hold dropped without write");

  property p_wake_vec;
    s_deep_wake0 |=> cpu_reset_o && rstf_ff && !cyclic_mode_o &&
      boot_vector_o == RESET_VEC +
        ($past(fatal_nmi_i) ? `CSD_OFS_FNMI :
         $past(fatal_interrupt_i) ? `CSD_OFS_FINT : 32'h0000_0000)
      ##2 state_ff == CSD_RUN;
  endproperty
  a_wake_vec: assert property (p_wake_vec)
    else $error("factor-0 DeepSTOP wake wrong");

  property p_wake_cyc;
    deep && !w0 && w1 |=> cyclic_mode_o &&
      boot_vector_o == `CSD_CYC_BASE +
        ($past(fatal_nmi_i) ? `CSD_OFS_FNMI :
         $past(fatal_interrupt_i) ? `CSD_OFS_FINT : 32'h0000_0000);
  endproperty
  a_wake_cyc: assert property (p_wake_cyc)
    else $error("factor-1 DeepSTOP wake wrong");

endmodule

// File: test/csd_wake_src.sv
// Purpose: Wake-up event source model for the standby bench.
// Assumes: Wake lines are active-high levels, low when idle.
// Notes:   A fire request raises one line of one factor group for
//          three cycles, then all lines fall back to idle low.
`timescale 1ns/1ps
module csd_wake_src (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       fire_i,
  input  wire logic       grp_i,
  input  wire logic [2:0] idx_i,
  output logic      [7:0] wake0_o,
  output logic      [7:0] wake1_o
);
  logic [1:0] cnt_ff;
  logic [7:0] line_ff;
  logic       grp_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cnt_ff  <= 2'h0;
      line_ff <= 8'h00;
      grp_ff  <= 1'b0;
    end else if (fire_i) begin
      cnt_ff  <= 2'h3;
      line_ff <= 8'h01 << idx_i;
      grp_ff  <= grp_i;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end

  // Idle lines read low once the pulse has run out
  assign wake0_o = (cnt_ff != 2'h0 && !grp_ff) ? line_ff : 8'h00;
  assign wake1_o = (cnt_ff != 2'h0 && grp_ff) ? line_ff : 8'h00;
endmodule

// File: test/tb_top.sv
// Purpose: Self-checking bench of the chip standby controller.
// Assumes: Register port with read data in the cycle after the strobe.
// Notes:   Walks STOP, DeepSTOP factor 0 and DeepSTOP factor 1.
`timescale 1ns/1ps
`include "csd_cfg.svh"
module tb_top;
  import csd_pkg::*;
  localparam logic [31:0] RVEC = 32'h0000_1000;
  logic        sys_clk_i, rst_b_i, wr_i, rd_i, fire, grp, f_nmi, f_int;
  logic [2:0]  idx;
  logic [7:0]  addr_i, wk0, wk1, per, hold;
  logic [31:0] wr_data_i, rd_data_o, vec, d;
  logic        cclk, mosc, fosc, pll, hv, iso, ram, crst, cyc;
  int          error_cnt, comparisons, rst_seen;

  csd_wake_src u_src (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .fire_i(fire), .grp_i(grp), .idx_i(idx), .wake0_o(wk0),
    .wake1_o(wk1));

  csd_ctrl #(.RESET_VEC(RVEC)) u_dut (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .wake0_i(wk0),
    .wake1_i(wk1), .fatal_nmi_i(f_nmi), .fatal_interrupt_i(f_int),
    .cpu_clk_en_o(cclk), .main_osc_en_o(mosc), .fast_osc_en_o(fosc),
    .pll_en_o(pll), .hv_osc_en_o(hv), .iso_pwr_en_o(iso),
    .local_ram_pwr_o(ram), .periph_clk_en_o(per), .io_hold_o(hold),
    .cpu_reset_o(crst), .cyclic_mode_o(cyc), .boot_vector_o(vec));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (crst === 1'b1) begin
      rst_seen++;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= v;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 v = rd_data_o;
  endtask

  task automatic wait_st(input csd_state_t st);
    logic [31:0] s;
    for (int n = 0; n < 30; n++) begin
      rd(`CSD_A_STAT, s);
      if (s[4:0] === st) begin
        return;
      end
    end
    chk("state", {27'h0, s[4:0]}, {27'h0, st});
    complete_run();
  endtask

  task automatic fire_wake(input logic g, input logic [2:0] i);
    @(posedge sys_clk_i);
    fire <= 1'b1;
    grp  <= g;
    idx  <= i;
    @(posedge sys_clk_i);
    fire <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b_i, wr_i, rd_i, fire, grp, f_nmi, f_int} = 7'h00;
    {idx, addr_i, wr_data_i} = 43'h0;
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk("cpu_clk", cclk, 1);
    chk("io_hold", hold, 0);
    rd(`CSD_A_WMSK0, d);
    chk("wmsk0", d, 32'h0000_00FF);
    rd(8'h3C, d);
    chk("unmapped", d, 0);
    wr(`CSD_A_WCLR0, 32'h0000_00FF);
    wr(`CSD_A_WMSK0, 32'h0000_00FE);
    wr(`CSD_A_OSCM, 32'h0000_0001);
    wr(`CSD_A_PMSK, 32'h0000_000F);
    wr(`CSD_A_STPT, 32'h0000_0001);
    chk("cpu_clk", cclk, 0);
    wait_st(CSD_STOP);
    rd(`CSD_A_STPT, d);
    chk("stpt", d, 0);
    chk("main_osc", mosc, 1);
    chk("fast_osc", fosc, 0);
    chk("pll", pll, 0);
    chk("hv_osc", hv, 1);
    chk("periph", per, 8'h0F);
    chk("io_hold", hold, 8'hFF);
    chk("ram", ram, 1);
    fire_wake(1'b0, 3'd1);
    rd(`CSD_A_STAT, d);
    chk("masked", d[4:0], CSD_STOP);
    fire_wake(1'b0, 3'd0);
    wait_st(CSD_RUN);
    chk("cpu_clk", cclk, 1);
    rd(`CSD_A_STPT, d);
    chk("stpt", d, 0);
    rd(`CSD_A_WFLG0, d);
    chk("wflg0", d, 32'h0000_0001);
    wr(`CSD_A_WCLR0, 32'h0000_0001);
    rd(`CSD_A_WFLG0, d);
    chk("wflg0", d, 0);
    f_nmi <= 1'b1;
    wr(`CSD_A_VMON, 32'h0000_0000);
    wr(`CSD_A_PSC, 32'h0000_0002);
    wait_st(CSD_DEEP);
    chk("iso", iso, 0);
    chk("main_osc", mosc, 1);
    chk("fast_osc", fosc, 0);
    chk("pll", pll, 0);
    chk("hv_osc", hv, 0);
    chk("ram", ram, 0);
    chk("periph", per, 8'h0F);
    chk("io_hold", hold, 8'hFF);
    fire_wake(1'b0, 3'd0);
    wait_st(CSD_RUN);
    chk("vector", vec, RVEC + 32'h0000_00E0);
    chk("cyclic", cyc, 0);
    chk("pll", pll, 0);
    chk("io_hold", hold, 8'hFF);
    rd(`CSD_A_RSTF, d);
    chk("rstf", d, 32'h0000_0001);
    wr(`CSD_A_RSTF, 32'h0000_0001);
    wr(`CSD_A_PLL, 32'h0000_0001);
    chk("pll", pll, 1);
    wr(`CSD_A_HOLD, 32'h0000_0000);
    chk("io_hold", hold, 0);
    f_nmi <= 1'b0;
    f_int <= 1'b1;
    wr(`CSD_A_WMSK0, 32'h0000_00FF);
    wr(`CSD_A_WMSK1, 32'h0000_00FB);
    wr(`CSD_A_VMON, 32'h0000_0001);
    wr(`CSD_A_PSC, 32'h0000_0002);
    wait_st(CSD_DEEP);
    chk("hv_osc", hv, 1);
    fire_wake(1'b1, 3'd2);
    wait_st(CSD_RUN);
    chk("vector", vec, 32'hFE80_00F0);
    chk("cyclic", cyc, 1);
    rd(`CSD_A_WFLG1, d);
    chk("wflg1", d, 32'h0000_0004);
    chk("cpu_reset", rst_seen, 4);
    complete_run();
  end
endmodule
